// File: ufcp_port.sv
// Serial port with optional hardware flow control, 8 data bits, even or no parity.
// Assumes configuration is static while frames are in flight.
// Overview of operation
// - Receive serial data on rxd, transmit serial data on txd.
// - ctsIn is flow control input, rtsOut is flow control output.
// - Flow control selectable on or off; off after reset.
// - With flow control on, in power saving or unable to accept, flow output driven OFF.
// - Programmable baud divider, rate 25 MHz divided by baudDiv, up to 1 Mbps.
// - Frame has 8 data bits, 1 stop bit, even parity or none.
// - After reset frame is 8N1.
`default_nettype none
module ufcp_port (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ufcp_pkg::ufcp_cfg_type cfg,
  input wire logic cfgLoad,
  input wire logic powerSave,
  input wire logic rxd,
  output logic txd,
  input wire logic ctsIn_n,
  output logic rtsOut_n,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  output logic rxValid,
  output logic [7:0] rxData,
  output ufcp_pkg::ufcp_rxerr_type rxErr,
  input wire logic rxReady
);
  import ufcp_pkg::*;

  function automatic logic evenPar(input logic [7:0] d);
    return ^d;
  endfunction

  ufcp_cfg_type cfg_ff, nxt_cfg;
  always_comb begin
    nxt_cfg = cfg_ff;
    if (cfgLoad) begin
      nxt_cfg = cfg;
      if (cfg.baudDiv < DIV_W'(MIN_DIV)) begin
        nxt_cfg.baudDiv = DIV_W'(MIN_DIV);
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= '{baudDiv: DIV_RESET, parityEn: PARITY_RESET, flowEn: FLOW_RESET};
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Three-stage synchronisers for pins
  logic [2:0] rxSync_ff, ctsSync_ff;
  logic rxIn_ff, nxt_rxIn, ctsIn_ff, nxt_ctsIn;
  always_comb begin
    nxt_rxIn = (rxSync_ff[1] == rxSync_ff[2]) ? rxSync_ff[2] : rxIn_ff;
    nxt_ctsIn = (ctsSync_ff[1] == ctsSync_ff[2]) ? ctsSync_ff[2] : ctsIn_ff;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSync_ff <= 3'h7;
      ctsSync_ff <= 3'h7;
      rxIn_ff <= 1'b1;
      ctsIn_ff <= 1'b1;
    end else begin
      rxSync_ff <= {rxSync_ff[1:0], rxd};
      ctsSync_ff <= {ctsSync_ff[1:0], ctsIn_n};
      rxIn_ff <= nxt_rxIn;
      ctsIn_ff <= nxt_ctsIn;
    end
  end

  // Transmitter
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} ufcp_txst_type;
  ufcp_txst_type txSt_ff, nxt_txSt;
  logic [DIV_W-1:0] txCnt_ff, nxt_txCnt;
  logic [3:0] txBit_ff, nxt_txBit;
  logic [10:0] txSh_ff, nxt_txSh;
  logic txd_ff, nxt_txd;
  logic txAllowed;

  assign txAllowed = !cfg_ff.flowEn || !ctsIn_ff;
  assign txReady = (txSt_ff == TX_IDLE) && txAllowed;
  assign txd = txd_ff;

  always_comb begin
    nxt_txSt = txSt_ff;
    nxt_txCnt = txCnt_ff;
    nxt_txBit = txBit_ff;
    nxt_txSh = txSh_ff;
    nxt_txd = txd_ff;
    case (txSt_ff)
      TX_IDLE: begin
        nxt_txd = 1'b1;
        if (txValid && txAllowed) begin
          // Start, data LSB first, optional parity, stop
          nxt_txSh = cfg_ff.parityEn ? {1'b1, 1'b1, evenPar(txData), txData}
                                     : {1'b1, 1'b1, 1'b1, txData};
          nxt_txd = 1'b0;
          nxt_txCnt = cfg_ff.baudDiv - 16'h0001;
          nxt_txBit = cfg_ff.parityEn ? BITS_PAR : BITS_NOPAR;
          nxt_txSt = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (txCnt_ff == '0) begin
          nxt_txCnt = cfg_ff.baudDiv - 16'h0001;
          if (txBit_ff == 4'h0) begin
            nxt_txSt = TX_IDLE;
            nxt_txd = 1'b1;
          end else begin
            nxt_txd = txSh_ff[0];
            nxt_txSh = {1'b1, txSh_ff[10:1]};
            nxt_txBit = txBit_ff - 4'h1;
          end
        end else begin
          nxt_txCnt = txCnt_ff - 16'h0001;
        end
      end
      default: nxt_txSt = TX_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txSt_ff <= TX_IDLE;
      txCnt_ff <= '0;
      txBit_ff <= 4'h0;
      txSh_ff <= 11'h7FF;
      txd_ff <= 1'b1;
    end else begin
      txSt_ff <= nxt_txSt;
      txCnt_ff <= nxt_txCnt;
      txBit_ff <= nxt_txBit;
      txSh_ff <= nxt_txSh;
      txd_ff <= nxt_txd;
    end
  end

  // Receiver
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_SHIFT} ufcp_rxst_type;
  ufcp_rxst_type rxSt_ff, nxt_rxSt;
  logic [DIV_W-1:0] rxCnt_ff, nxt_rxCnt;
  logic [3:0] rxBit_ff, nxt_rxBit;
  logic [9:0] rxSh_ff, nxt_rxSh;
  logic rxDone;
  logic [9:0] rxWord;
  logic holdFull, holdEmpty;
  logic [9:0] holdOut;
  logic [8:0] dataPar;

  always_comb begin
    nxt_rxSt = rxSt_ff;
    nxt_rxCnt = rxCnt_ff;
    nxt_rxBit = rxBit_ff;
    nxt_rxSh = rxSh_ff;
    rxDone = 1'b0;
    rxWord = '0;
    dataPar = cfg_ff.parityEn ? rxSh_ff[8:0] : {1'b0, rxSh_ff[9:2]};
    case (rxSt_ff)
      RX_IDLE: begin
        if (!rxIn_ff) begin
          nxt_rxSt = RX_START;
          nxt_rxCnt = {1'b0, cfg_ff.baudDiv[DIV_W-1:1]};
        end
      end
      RX_START: begin
        if (rxCnt_ff == '0) begin
          if (rxIn_ff) begin
            nxt_rxSt = RX_IDLE;
          end else begin
            nxt_rxSt = RX_SHIFT;
            nxt_rxCnt = cfg_ff.baudDiv - 16'h0001;
            nxt_rxBit = cfg_ff.parityEn ? BITS_PAR : BITS_NOPAR;
          end
        end else begin
          nxt_rxCnt = rxCnt_ff - 16'h0001;
        end
      end
      RX_SHIFT: begin
        if (rxCnt_ff == '0) begin
          nxt_rxCnt = cfg_ff.baudDiv - 16'h0001;
          nxt_rxBit = rxBit_ff - 4'h1;
          nxt_rxSh = {rxIn_ff, rxSh_ff[9:1]};
          if (rxBit_ff == 4'h1) begin
            nxt_rxSt = RX_IDLE;
            rxDone = 1'b1;
            dataPar = cfg_ff.parityEn ? rxSh_ff[9:1] : {1'b0, rxSh_ff[9:2]};
            rxWord[7:0] = dataPar[7:0];
            rxWord[8] = !rxIn_ff;
            rxWord[9] = cfg_ff.parityEn && (evenPar(dataPar[7:0]) != dataPar[8]);
          end
        end else begin
          nxt_rxCnt = rxCnt_ff - 16'h0001;
        end
      end
      default: nxt_rxSt = RX_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSt_ff <= RX_IDLE;
      rxCnt_ff <= '0;
      rxBit_ff <= 4'h0;
      rxSh_ff <= '0;
    end else begin
      rxSt_ff <= nxt_rxSt;
      rxCnt_ff <= nxt_rxCnt;
      rxBit_ff <= nxt_rxBit;
      rxSh_ff <= nxt_rxSh;
    end
  end

  ufcp_rx_hold #(.WIDTH(10)) uHold (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wrEn(rxDone),
    .wrData(rxWord),
    .rdEn(rxReady),
    .rdData(holdOut),
    .full(holdFull),
    .empty(holdEmpty)
  );

  assign rxValid = !holdEmpty;
  assign rxData = holdOut[7:0];
  assign rxErr = '{frameErr: holdOut[8], parityErr: holdOut[9]};

  // Flow output: ON (low) when flow disabled, or when awake and space left
  logic rts_ff, nxt_rts;
  always_comb begin
    nxt_rts = 1'b0;
    if (cfg_ff.flowEn && (powerSave || holdFull)) begin
      nxt_rts = 1'b1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_ff <= 1'b0;
    end else begin
      rts_ff <= nxt_rts;
    end
  end
  assign rtsOut_n = rts_ff;

  property p_rts_off;
    @(posedge core_clk) disable iff (!rst_n)
      (cfg_ff.flowEn && powerSave) |=> rtsOut_n;
  endproperty
  a_rts_off: assert property (p_rts_off) else $error("flow output not off in power save");

  property p_flow_reset;
    @(posedge core_clk) $rose(rst_n) |-> !cfg_ff.flowEn && !cfg_ff.parityEn;
  endproperty
  a_flow_reset: assert property (p_flow_reset) else $error("reset config not 8N1 no flow");

  sequence s_start;
    (txSt_ff == TX_IDLE) && txValid && txAllowed;
  endsequence
  property p_tx_start;
    @(posedge core_clk) disable iff (!rst_n) s_start |=> !txd && (txSt_ff == TX_SHIFT);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit not low");

  property p_tx_cts;
    @(posedge core_clk) disable iff (!rst_n)
      (cfg_ff.flowEn && ctsIn_ff && txSt_ff == TX_IDLE) |=> (txSt_ff == TX_IDLE);
  endproperty
  a_tx_cts: assert property (p_tx_cts) else $error("sent while peer not clear");

  property p_idle_high;
    @(posedge core_clk) disable iff (!rst_n) (txSt_ff == TX_IDLE && !txValid) |=> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");

  property p_bits;
    @(posedge core_clk) disable iff (!rst_n)
      s_start |=> (txBit_ff == (cfg_ff.parityEn ? BITS_PAR : BITS_NOPAR));
  endproperty
  a_bits: assert property (p_bits) else $error("wrong bit count");

  property p_div;
    @(posedge core_clk) disable iff (!rst_n) cfg_ff.baudDiv >= DIV_W'(MIN_DIV);
  endproperty
  a_div: assert property (p_div) else $error("rate above maximum");

  property p_rts_free;
    @(posedge core_clk) disable iff (!rst_n) !cfg_ff.flowEn |=> !rtsOut_n;
  endproperty
  a_rts_free: assert property (p_rts_free) else $error("flow output active while off");
endmodule // ufcp_port
`default_nettype wire

// File: ufcp_pkg.sv
// Package for the serial port with flow control: frame layout, timing and carriers.
// Assumes a single 25 MHz core clock and an active-low asynchronous reset.
`default_nettype none
package ufcp_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int MAX_BAUD = 1000000;
  localparam int MIN_DIV = CLK_HZ / MAX_BAUD;
  localparam int DATA_BITS = 8;
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h00D9;
  localparam logic PARITY_RESET = 1'b0;
  localparam logic FLOW_RESET = 1'b0;
  localparam logic [3:0] BITS_NOPAR = 4'h9;
  localparam logic [3:0] BITS_PAR = 4'hA;

  typedef struct packed {
    logic [DIV_W-1:0] baudDiv;
    logic parityEn;
    logic flowEn;
  } ufcp_cfg_type;

  typedef struct packed {
    logic frameErr;
    logic parityErr;
  } ufcp_rxerr_type;
endpackage
`default_nettype wire

// File: ufcp_rx_hold.sv
// Two-word hold memory for received characters with registered read data.
// Assumes writer and reader sit on core_clk; a write while full is dropped.
`default_nettype none
module ufcp_rx_hold #(
  parameter int WIDTH = 10
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdEn,
  output logic [WIDTH-1:0] rdData,
  output logic full,
  output logic empty
);
  logic [WIDTH-1:0] mem_ff [2];
  logic wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
  logic [1:0] cnt_ff, nxt_cnt;
  logic [WIDTH-1:0] rdData_ff, nxt_rdData;

  assign full = (cnt_ff == 2'h2);
  assign empty = (cnt_ff == 2'h0);
  assign rdData = rdData_ff;

  always_comb begin
    nxt_wrPtr = wrPtr_ff;
    nxt_rdPtr = rdPtr_ff;
    nxt_cnt = cnt_ff;
    nxt_rdData = rdData_ff;
    if (wrEn && !full) begin
      nxt_wrPtr = ~wrPtr_ff;
      // New word goes straight to the head when nothing older stays
      if (empty || (rdEn && cnt_ff == 2'h1)) begin
        nxt_rdData = wrData;
      end
    end
    if (rdEn && !empty) begin
      nxt_rdPtr = ~rdPtr_ff;
      if (!(wrEn && cnt_ff == 2'h1)) begin
        nxt_rdData = mem_ff[~rdPtr_ff];
      end
    end
    nxt_cnt = cnt_ff + {1'b0, (wrEn && !full)} - {1'b0, (rdEn && !empty)};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_ff <= 1'b0;
      rdPtr_ff <= 1'b0;
      cnt_ff <= 2'h0;
      rdData_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      cnt_ff <= nxt_cnt;
      rdData_ff <= nxt_rdData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wrEn && !full) begin
      mem_ff[wrPtr_ff] <= wrData;
    end
  end
endmodule // ufcp_rx_hold
`default_nettype wire

// File: ufcp_host_model.sv
// Host peer for the serial port: sends frames on rxd and decodes frames seen on txd.
// Assumes the bench keeps bitDiv and parOn equal to the loaded port configuration.
`default_nettype none
module ufcp_host_model (
  input wire logic core_clk,
  input wire logic txd,
  input wire logic rtsOut_n,
  input wire logic holdOff,
  input wire logic [31:0] bitDiv,
  input wire logic parOn,
  output logic rxd,
  output logic ctsIn_n,
  output logic gotValid,
  output logic [9:0] gotWord
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shift;
  assign ctsIn_n = holdOff;
  initial begin
    rxd = 1'b1;
  end
  task automatic bitTime(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic send(input logic [7:0] d, input logic badPar, input logic badStop);
    int i;
    while (rtsOut_n !== 1'b0) bitTime(1);
    rxd = 1'b0;
    bitTime(bitDiv);
    for (i = 0; i < 8; i++) begin
      rxd = d[i];
      bitTime(bitDiv);
    end
    if (parOn) begin
      rxd = ^d ^ badPar;
      bitTime(bitDiv);
    end
    rxd = ~badStop;
    bitTime(bitDiv);
    rxd = 1'b1;
    bitTime(bitDiv);
  endtask
  initial begin : decode
    int k;
    logic bad;
    gotValid = 1'b0;
    gotWord = '0;
    forever begin
      @(negedge txd);
      repeat (bitDiv / 2) @(posedge core_clk);
      bad = txd;
      for (k = 0; k < 8; k++) begin
        repeat (bitDiv) @(posedge core_clk);
        shift[k] = txd;
      end
      if (parOn) begin
        repeat (bitDiv) @(posedge core_clk);
        bad = bad | (txd != ^shift);
      end
      repeat (bitDiv) @(posedge core_clk);
      bad = bad | !txd;
      #1;
      gotWord = {1'b0, bad, shift};
      gotValid = 1'b1;
      @(posedge core_clk);
      #1;
      gotValid = 1'b0;
    end
  end
endmodule // ufcp_host_model
`default_nettype wire

// File: ufcp_port_tb_top.sv
// Self-checking bench for the serial port: both directions, parity, flow control.
// Assumes the host model shares core_clk; expectations queue until results appear.
`default_nettype none
module ufcp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ufcp_pkg::*;
  logic core_clk, rst_n, cfgLoad, powerSave, txValid, rxReady, holdOff, parOn;
  logic txd, rtsOut_n, txReady, rxValid, rxd, ctsIn_n, gotValid;
  logic [7:0] txData, rxData;
  logic [9:0] gotWord;
  ufcp_cfg_type cfg;
  ufcp_rxerr_type rxErr;
  int bitDiv, num_errors, check_count;
  logic [9:0] txExp[$];
  logic [9:0] rxExp[$];
  ufcp_port u_dut (.core_clk(core_clk), .rst_n(rst_n), .cfg(cfg), .cfgLoad(cfgLoad),
    .powerSave(powerSave), .rxd(rxd), .txd(txd), .ctsIn_n(ctsIn_n), .rtsOut_n(rtsOut_n),
    .txValid(txValid), .txData(txData), .txReady(txReady), .rxValid(rxValid),
    .rxData(rxData), .rxErr(rxErr), .rxReady(rxReady));
  ufcp_host_model u_host (.core_clk(core_clk), .txd(txd), .rtsOut_n(rtsOut_n),
    .holdOff(holdOff), .bitDiv(bitDiv), .parOn(parOn), .rxd(rxd), .ctsIn_n(ctsIn_n),
    .gotValid(gotValid), .gotWord(gotWord));
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic setCfg(input logic [15:0] div, input logic par, input logic flow);
    cfg = '{baudDiv: div, parityEn: par, flowEn: flow};
    cfgLoad = 1'b1;
    tick(1);
    cfgLoad = 1'b0;
    bitDiv = (div < MIN_DIV) ? MIN_DIV : int'(div);
    parOn = par;
  endtask
  task automatic txBurst(input int n);
    int k, w;
    for (k = 0; k < n; k++) begin
      txValid = 1'b1;
      txData = 8'($urandom());
      w = 0;
      @(posedge core_clk);
      while (txReady !== 1'b1 && w < 9000) begin
        @(posedge core_clk);
        w++;
      end
      txExp.push_back({2'b00, txData});
      #1;
    end
    txValid = 1'b0;
  endtask
  task automatic rxSend(input logic badPar, input logic badStop);
    logic [7:0] d;
    d = 8'($urandom());
    rxExp.push_back({badStop, badPar, d});
    u_host.send(d, badPar, badStop);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while ((txExp.size() != 0 || rxExp.size() != 0) && n < 20000) begin
      tick(1);
      n++;
    end
    check("queues empty", 10'h000, 10'(txExp.size() + rxExp.size()));
  endtask
  always @(posedge core_clk) begin
    if (gotValid === 1'b1) begin
      if (txExp.size() == 0) check("txd frame", 10'h3FF, gotWord);
      else check("txd frame", txExp.pop_front(), gotWord);
    end
    if (rxValid === 1'b1 && rxReady === 1'b1) begin
      if (rxExp.size() == 0) check("rx word", 10'h3FF, {rxErr, rxData});
      else check("rx word", rxExp.pop_front(), {rxErr, rxData});
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    conclude();
  end
  initial begin
    {rst_n, cfgLoad, powerSave, txValid, txData, holdOff, parOn} = '0;
    cfg = '0;
    rxReady = 1'b1;
    bitDiv = int'(DIV_RESET);
    num_errors = 0;
    check_count = 0;
    void'($urandom(37713));
    tick(12);
    rst_n = 1'b1;
    check("reset state", 10'h00A, {6'h00, txd, rtsOut_n, txReady, rxValid});
    fork
      txBurst(1);
      rxSend(1'b0, 1'b0);
    join
    drain();
    setCfg(16'h0020, 1'b0, 1'b0);
    fork
      txBurst(4);
      repeat (3) rxSend(1'b0, 1'b0);
    join
    drain();
    setCfg(16'h0003, 1'b1, 1'b0);
    fork
      txBurst(3);
      begin
        rxSend(1'b0, 1'b0);
        rxSend(1'b1, 1'b0);
        rxSend(1'b0, 1'b1);
      end
    join
    drain();
    setCfg(16'h0020, 1'b0, 1'b1);
    holdOff = 1'b1;
    tick(6);
    check("ready cts off", 10'h000, {9'h000, txReady});
    powerSave = 1'b1;
    tick(3);
    check("rts power save", 10'h001, {9'h000, rtsOut_n});
    powerSave = 1'b0;
    tick(3);
    check("rts awake", 10'h000, {9'h000, rtsOut_n});
    fork
      txBurst(2);
      begin
        tick(50);
        holdOff = 1'b0;
      end
    join
    rxReady = 1'b0;
    repeat (2) rxSend(1'b0, 1'b0);
    tick(3);
    check("rts full", 10'h003, {8'h00, rtsOut_n, rxValid});
    fork
      rxSend(1'b0, 1'b0);
      begin
        tick(20);
        rxReady = 1'b1;
      end
    join
    drain();
    conclude();
  end
endmodule // ufcp_port_tb_top
`default_nettype wire
